// *** core/sas_pkg.sv ***
// Constants and types shared by the ADC sequencer design
package sas_pkg;
    // Result and bus widths
    localparam int RES_W = 11;
    localparam int BUS_W = 12;
    localparam int NUM_REGS = 4;
    // Phase lengths in system clock cycles
    localparam logic [5:0] ACQ_CYCLES = 6'd20;
    localparam logic [5:0] CONV_CYCLES = 6'd40;
    // Register addresses on the two address lines
    localparam logic [1:0] ADDR_PHASE_ONE = 2'h0;
    localparam logic [1:0] ADDR_PHASE_TWO = 2'h1;
    localparam logic [1:0] ADDR_PHASE_THREE = 2'h2;
    localparam logic [1:0] ADDR_AUX = 2'h3;
    // Channel set codes, {hi, lo}
    localparam logic [1:0] MODE_P23 = 2'h0;
    localparam logic [1:0] MODE_P23_AUX = 2'h1;
    localparam logic [1:0] MODE_P123 = 2'h2;
    localparam logic [1:0] MODE_P123_AUX = 2'h3;
    // Values after reset
    localparam logic [RES_W-1:0] RES_RST = 11'h000;
    localparam logic [BUS_W-1:0] BUS_RST = 12'h000;
    localparam logic [5:0] CNT_RST = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10
    } sas_state_e;
endpackage : sas_pkg

// *** core/sas_sync.sv ***
// Two-stage level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sas_sync (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            meta_ff <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : sas_sync
`default_nettype wire

// *** core/sas_top.sv ***
// Simultaneous-sampling ADC sequencer: sampling, SAR conversion, result readout
//
// Summary of operation
// - Each selected channel takes 40 clocks to convert, one after another.
// - Sample-and-hold acquisition lasts 20 clocks regardless of channel count.
// - Up to four channels are held together, then digitised one at a time.
// - Acquisition starts on the clock edge after start is seen high.
// - Busy goes low at conversion start, low 40 clocks per channel.
// - Busy returns high on the same edge that all converted result registers are updated.
// - Old results stay readable until n*40 clocks after conversion start.
// - Mode pins pick the channel set: 2+3, +aux, 1+2+3, all four.
// - Aux route pins pick one of four auxiliary inputs for the aux channel.
// - All channels use values captured on the clock edge that starts acquisition.
// - Eleven-bit result sits in bus bits 11:1; bit 0 reads zero.
// - Results are twos complement, left justified.
// - Each channel owns one register; sequences overwrite only their own.
// - Aux register holds the aux input chosen for that sequence.
// - Address 00 phase one, 01 phase two, 10 phase three, 11 aux.
// - Chip select and read strobe are active low; no response without select.
// - Addressed register drives the bus from one clock after select and read go low until one clock after either rises.
`timescale 1ns/1ns
`default_nettype none
module sas_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sample_start,
    input wire logic chan_set_sel_lo,
    input wire logic chan_set_sel_hi,
    input wire logic aux_route_sel_lo,
    input wire logic aux_route_sel_hi,
    input wire logic reg_addr_lo,
    input wire logic reg_addr_hi,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic [sas_pkg::RES_W-1:0] phase_input_one,
    input wire logic [sas_pkg::RES_W-1:0] phase_input_two,
    input wire logic [sas_pkg::RES_W-1:0] phase_input_three,
    input wire logic [sas_pkg::RES_W-1:0] aux_input_zero,
    input wire logic [sas_pkg::RES_W-1:0] aux_input_one,
    input wire logic [sas_pkg::RES_W-1:0] aux_input_two,
    input wire logic [sas_pkg::RES_W-1:0] aux_input_three,
    output logic busy_n,
    output logic [sas_pkg::BUS_W-1:0] data_out,
    output logic data_oe_n
);
    sas_pkg::sas_state_e state_ff;
    logic start_sync;
    logic start_seen_ff;
    logic start_det;
    logic [5:0] cnt_ff;
    logic [1:0] chan_idx_ff;
    logic [1:0] mode_ff;
    logic [2:0] chan_cnt_ff;
    logic [sas_pkg::RES_W-1:0] held_ff [sas_pkg::NUM_REGS];
    logic [sas_pkg::RES_W-1:0] shadow_ff [sas_pkg::NUM_REGS];
    logic [sas_pkg::RES_W-1:0] result_ff [sas_pkg::NUM_REGS];
    logic [sas_pkg::RES_W-1:0] approx_ff;
    logic [sas_pkg::RES_W-1:0] trial;
    logic [sas_pkg::RES_W-1:0] aux_pick;
    logic [1:0] chan_id;
    logic [3:0] conv_mask;
    logic chan_last_cycle;
    logic seq_done;
    logic [1:0] rd_addr;
    logic rd_active;

    // Start input crosses into the clock domain first
    sas_sync u_start_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(sample_start),
        .sync_out(start_sync)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            start_seen_ff <= 1'b0;
        else
            start_seen_ff <= start_sync;
    end

    // Rising edge only; a start held high does not retrigger
    assign start_det = start_sync && !start_seen_ff;
    // Converted channels run from a base register upward
    assign chan_id = (mode_ff[1] ? 2'h0 : 2'h1) + chan_idx_ff;
    always_comb
    begin
        unique case (mode_ff)
            sas_pkg::MODE_P23: conv_mask = 4'h6;
            sas_pkg::MODE_P23_AUX: conv_mask = 4'hE;
            sas_pkg::MODE_P123: conv_mask = 4'h7;
            sas_pkg::MODE_P123_AUX: conv_mask = 4'hF;
        endcase
    end

    always_comb
    begin
        unique case ({aux_route_sel_hi, aux_route_sel_lo})
            2'h0: aux_pick = aux_input_zero;
            2'h1: aux_pick = aux_input_one;
            2'h2: aux_pick = aux_input_two;
            2'h3: aux_pick = aux_input_three;
        endcase
    end

    assign chan_last_cycle = (state_ff == sas_pkg::ST_CONV)
        && (cnt_ff == sas_pkg::CONV_CYCLES - 6'd1);
    assign seq_done = chan_last_cycle && ({1'b0, chan_idx_ff} == chan_cnt_ff - 3'd1);

    // Sequencer: idle, acquisition, per-channel conversion
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state_ff <= sas_pkg::ST_IDLE;
            cnt_ff <= sas_pkg::CNT_RST;
            chan_idx_ff <= 2'h0;
        end
        else
        begin
            unique case (state_ff)
                sas_pkg::ST_IDLE:
                begin
                    if (start_det)
                    begin
                        state_ff <= sas_pkg::ST_ACQ;
                        cnt_ff <= sas_pkg::CNT_RST;
                    end
                end
                sas_pkg::ST_ACQ:
                begin
                    if (cnt_ff == sas_pkg::ACQ_CYCLES - 6'd1)
                    begin
                        state_ff <= sas_pkg::ST_CONV;
                        cnt_ff <= sas_pkg::CNT_RST;
                        chan_idx_ff <= 2'h0;
                    end
                    else
                        cnt_ff <= cnt_ff + 6'd1;
                end
                sas_pkg::ST_CONV:
                begin
                    if (seq_done)
                        state_ff <= sas_pkg::ST_IDLE;
                    if (chan_last_cycle)
                    begin
                        cnt_ff <= sas_pkg::CNT_RST;
                        chan_idx_ff <= chan_idx_ff + 2'h1;
                    end
                    else
                        cnt_ff <= cnt_ff + 6'd1;
                end
                default:
                begin
                    state_ff <= sas_pkg::ST_IDLE;
                    cnt_ff <= sas_pkg::CNT_RST;
                end
            endcase
        end
    end

    // Mode and aux route are latched once, so mid-sequence changes are harmless
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            mode_ff <= sas_pkg::MODE_P23;
            chan_cnt_ff <= 3'd2;
        end
        else if (state_ff == sas_pkg::ST_IDLE && start_det)
        begin
            mode_ff <= {chan_set_sel_hi, chan_set_sel_lo};
            chan_cnt_ff <= 3'd2 + {2'b00, chan_set_sel_hi} + {2'b00, chan_set_sel_lo};
        end
    end

    // Sample-and-hold: all four inputs frozen at the start edge
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < sas_pkg::NUM_REGS; i++)
                held_ff[i] <= sas_pkg::RES_RST;
        end
        else if (state_ff == sas_pkg::ST_IDLE && start_det)
        begin
            held_ff[sas_pkg::ADDR_PHASE_ONE] <= phase_input_one;
            held_ff[sas_pkg::ADDR_PHASE_TWO] <= phase_input_two;
            held_ff[sas_pkg::ADDR_PHASE_THREE] <= phase_input_three;
            held_ff[sas_pkg::ADDR_AUX] <= aux_pick;
        end
    end

    // Successive approximation, one bit decision per cycle, MSB first
    assign trial = (cnt_ff < 6'(sas_pkg::RES_W))
        ? (approx_ff | (11'h400 >> cnt_ff)) : approx_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            approx_ff <= sas_pkg::RES_RST;
        else if (state_ff != sas_pkg::ST_CONV || chan_last_cycle)
            approx_ff <= sas_pkg::RES_RST;
        else if (trial <= held_ff[chan_id])
            approx_ff <= trial;
    end

    // Per-channel result waits in a shadow so old data stays readable
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < sas_pkg::NUM_REGS; i++)
                shadow_ff[i] <= sas_pkg::RES_RST;
        end
        else if (chan_last_cycle)
            shadow_ff[chan_id] <= {~approx_ff[10], approx_ff[9:0]};
    end

    // All converted registers update together at the end
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < sas_pkg::NUM_REGS; i++)
                result_ff[i] <= sas_pkg::RES_RST;
        end
        else if (seq_done)
        begin
            for (int i = 0; i < sas_pkg::NUM_REGS; i++)
            begin
                if (conv_mask[i] && 2'(i) == chan_id)
                    result_ff[i] <= {~approx_ff[10], approx_ff[9:0]};
                else if (conv_mask[i])
                    result_ff[i] <= shadow_ff[i];
            end
        end
    end

    // Busy low exactly for the conversion phase
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            busy_n <= 1'b1;
        else if (state_ff == sas_pkg::ST_ACQ && cnt_ff == sas_pkg::ACQ_CYCLES - 6'd1)
            busy_n <= 1'b0;
        else if (seq_done)
            busy_n <= 1'b1;
    end

    // Read port; one clock of latency from strobe to bus
    assign rd_addr = {reg_addr_hi, reg_addr_lo};
    assign rd_active = !cs_n && !rd_n;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            data_out <= sas_pkg::BUS_RST;
            data_oe_n <= 1'b1;
        end
        else
        begin
            data_oe_n <= !rd_active;
            if (rd_active)
                data_out <= {result_ff[rd_addr], 1'b0};
            else
                data_out <= sas_pkg::BUS_RST;
        end
    end

    // Helper: count of cycles busy has been low
    logic [7:0] busy_lo_cnt_ff;
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            busy_lo_cnt_ff <= 8'h00;
        else if (busy_n)
            busy_lo_cnt_ff <= 8'h00;
        else
            busy_lo_cnt_ff <= busy_lo_cnt_ff + 8'h01;
    end
    sequence s_started;
        state_ff == sas_pkg::ST_IDLE && start_det;
    endsequence
    sequence s_conv_begins;
        $fell(busy_n) && state_ff == sas_pkg::ST_CONV && cnt_ff == sas_pkg::CNT_RST;
    endsequence
    property p_acq_len;
        @(posedge clk_sys) disable iff (!nrst)
        s_started |-> busy_n [*8] ##14 s_conv_begins;
    endproperty
    a_acq_len: assert property (p_acq_len)
        else $error("acquisition did not last 20 clocks");
    property p_busy_len;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(busy_n) |-> busy_lo_cnt_ff == 8'(chan_cnt_ff) * 8'd40;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy low time is not 40 clocks per channel");
    property p_busy_after_update;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(busy_n) |-> $past(seq_done);
    endproperty
    a_busy_after_update: assert property (p_busy_after_update)
        else $error("busy rose without result update");
    property p_old_data_held;
        @(posedge clk_sys) disable iff (!nrst)
        (!busy_n && !seq_done) |=> $stable(result_ff[0]) && $stable(result_ff[3]);
    endproperty
    a_old_data_held: assert property (p_old_data_held)
        else $error("result changed before end of sequence");
    property p_mode_count;
        @(posedge clk_sys) disable iff (!nrst)
        s_started |=> chan_cnt_ff == 3'd2 + 3'($past(chan_set_sel_hi))
            + 3'($past(chan_set_sel_lo));
    endproperty
    a_mode_count: assert property (p_mode_count)
        else $error("channel count does not follow mode pins");
    property p_unselected_kept;
        @(posedge clk_sys) disable iff (!nrst)
        (seq_done && mode_ff == sas_pkg::MODE_P23) |=>
            $stable(result_ff[0]) && $stable(result_ff[3]);
    endproperty
    a_unselected_kept: assert property (p_unselected_kept)
        else $error("unconverted register overwritten");
    property p_start_to_acq;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(start_sync) && state_ff == sas_pkg::ST_IDLE |=> state_ff == sas_pkg::ST_ACQ;
    endproperty
    a_start_to_acq: assert property (p_start_to_acq)
        else $error("start not taken on next edge");
    property p_sync_delay;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(start_sync) |-> $past(sample_start, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("start bypassed the synchroniser");
    property p_lsb_zero;
        @(posedge clk_sys) disable iff (!nrst)
        !data_oe_n |-> data_out[0] == 1'b0;
    endproperty
    a_lsb_zero: assert property (p_lsb_zero)
        else $error("bus bit 0 not zero");
    property p_read_drive;
        @(posedge clk_sys) disable iff (!nrst)
        (!cs_n && !rd_n) |=> !data_oe_n && data_out[11:1] == $past(result_ff[rd_addr]);
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("addressed register not on bus");
    property p_no_select;
        @(posedge clk_sys) disable iff (!nrst)
        cs_n |=> data_oe_n;
    endproperty
    a_no_select: assert property (p_no_select)
        else $error("bus driven without chip select");
    property p_reset_idle;
        @(posedge clk_sys)
        !nrst |=> busy_n && state_ff == sas_pkg::ST_IDLE;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");
endmodule : sas_top
`default_nettype wire

// *** verif/sas_host.sv ***
// Host processor model: sets mode pins, pulses start, reads result registers
`timescale 1ns/1ns
`default_nettype none
module sas_host (
    input wire logic clk_sys,
    input wire logic [sas_pkg::BUS_W-1:0] data_out,
    input wire logic data_oe_n,
    output var logic sample_start,
    output var logic chan_set_sel_lo,
    output var logic chan_set_sel_hi,
    output var logic aux_route_sel_lo,
    output var logic aux_route_sel_hi,
    output var logic reg_addr_lo,
    output var logic reg_addr_hi,
    output var logic cs_n,
    output var logic rd_n
);
    initial
    begin
        sample_start = 1'b0;
        chan_set_sel_lo = 1'b0;
        chan_set_sel_hi = 1'b0;
        aux_route_sel_lo = 1'b0;
        aux_route_sel_hi = 1'b0;
        reg_addr_lo = 1'b0;
        reg_addr_hi = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end

    task automatic setup(input logic [1:0] mode, input logic [1:0] route);
        @(negedge clk_sys);
        chan_set_sel_hi = mode[1];
        chan_set_sel_lo = mode[0];
        aux_route_sel_hi = route[1];
        aux_route_sel_lo = route[0];
        // Pins settle well ahead of the start edge
        repeat (2) @(negedge clk_sys);
    endtask : setup

    task automatic start_pulse;
        @(negedge clk_sys);
        sample_start = 1'b1;
        // Held two clocks so the synchroniser cannot miss it
        repeat (2) @(negedge clk_sys);
        sample_start = 1'b0;
    endtask : start_pulse

    task automatic read_reg(input logic [1:0] addr, input logic sel,
                            output logic [sas_pkg::BUS_W-1:0] data, output logic oe_n);
        @(negedge clk_sys);
        reg_addr_hi = addr[1];
        reg_addr_lo = addr[0];
        cs_n = ~sel;
        rd_n = 1'b0;
        @(negedge clk_sys);
        data = data_out;
        oe_n = data_oe_n;
        cs_n = 1'b1;
        rd_n = 1'b1;
    endtask : read_reg
endmodule : sas_host
`default_nettype wire

// *** verif/tb_simultaneous_adc_sequencer.sv ***
// Self-checking bench for the simultaneous-sampling ADC sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_simultaneous_adc_sequencer;
    logic clk_sys;
    logic nrst;
    logic sample_start, chan_set_sel_lo, chan_set_sel_hi, aux_route_sel_lo, aux_route_sel_hi;
    logic reg_addr_lo, reg_addr_hi, cs_n, rd_n;
    logic [sas_pkg::RES_W-1:0] ph_in [0:2];
    logic [sas_pkg::RES_W-1:0] ax_in [0:3];
    logic busy_n;
    logic [sas_pkg::BUS_W-1:0] data_out;
    logic data_oe_n;
    logic [sas_pkg::BUS_W-1:0] exp_reg [0:3];
    int failures;
    int tests_run;

    sas_top dut (.clk_sys(clk_sys), .nrst(nrst), .sample_start(sample_start),
        .chan_set_sel_lo(chan_set_sel_lo), .chan_set_sel_hi(chan_set_sel_hi),
        .aux_route_sel_lo(aux_route_sel_lo), .aux_route_sel_hi(aux_route_sel_hi),
        .reg_addr_lo(reg_addr_lo), .reg_addr_hi(reg_addr_hi), .cs_n(cs_n), .rd_n(rd_n),
        .phase_input_one(ph_in[0]), .phase_input_two(ph_in[1]),
        .phase_input_three(ph_in[2]), .aux_input_zero(ax_in[0]), .aux_input_one(ax_in[1]),
        .aux_input_two(ax_in[2]), .aux_input_three(ax_in[3]), .busy_n(busy_n),
        .data_out(data_out), .data_oe_n(data_oe_n));

    sas_host host (.clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n),
        .sample_start(sample_start), .chan_set_sel_lo(chan_set_sel_lo),
        .chan_set_sel_hi(chan_set_sel_hi), .aux_route_sel_lo(aux_route_sel_lo),
        .aux_route_sel_hi(aux_route_sel_hi), .reg_addr_lo(reg_addr_lo),
        .reg_addr_hi(reg_addr_hi), .cs_n(cs_n), .rd_n(rd_n));

    initial
    begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        failures = 0;
        tests_run = 0;
        foreach (ph_in[k]) ph_in[k] = 11'h000;
        foreach (ax_in[k]) ax_in[k] = 11'h000;
        foreach (exp_reg[k]) exp_reg[k] = 12'h000;
    end

    always #25 clk_sys = ~clk_sys;

    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [11:0] got, input logic [11:0] want);
        tests_run++;
        if (got !== want)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk

    // Unsigned front-end code to left-justified twos complement word
    function automatic logic [11:0] enc(input logic [10:0] v);
        return {v ^ 11'h400, 1'b0};
    endfunction : enc

    task automatic read_chk(input logic [1:0] addr, input logic [11:0] want);
        logic [11:0] d;
        logic oe;
        host.read_reg(addr, 1'b1, d, oe);
        chk({11'h000, oe}, 12'h000);
        chk(d, want);
    endtask : read_chk

    task automatic scn_reset;
        host.start_pulse();
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (60)
        begin
            @(negedge clk_sys);
            chk({11'h000, busy_n}, 12'h001);
        end
        for (int a = 0; a < 4; a++)
            read_chk(a[1:0], 12'h000);
    endtask : scn_reset

    task automatic scn_sequence(input int i);
        logic [1:0] mode;
        logic [1:0] ax;
        logic [10:0] base;
        logic [11:0] nxt [0:3];
        int n;
        int cnt;
        mode = i[1:0];
        ax = i[2:1];
        base = {i[2:0], 8'h00};
        ph_in[0] = base ^ 11'h0AA;
        ph_in[1] = base ^ 11'h755;
        ph_in[2] = base ^ 11'h7FF;
        ax_in[0] = base;
        ax_in[1] = base ^ 11'h3C3;
        ax_in[2] = base ^ 11'h5A5;
        ax_in[3] = base ^ 11'h7F0;
        host.setup(mode, ax);
        nxt = exp_reg;
        if (mode[1])
            nxt[0] = enc(ph_in[0]);
        nxt[1] = enc(ph_in[1]);
        nxt[2] = enc(ph_in[2]);
        if (mode[0])
            nxt[3] = enc(ax_in[ax]);
        n = 2 + int'(mode[0]) + int'(mode[1]);
        host.start_pulse();
        // Inputs move just after the hold instant; results must not follow
        @(negedge clk_sys);
        foreach (ph_in[k]) ph_in[k] = ~ph_in[k];
        foreach (ax_in[k]) ax_in[k] = ~ax_in[k];
        cnt = 3;
        while (busy_n !== 1'b0 && cnt < 100)
        begin
            @(negedge clk_sys);
            cnt++;
        end
        // Start edge, two synchroniser stages, detect, then acquisition
        chk(12'(cnt), 12'(sas_pkg::ACQ_CYCLES) + 12'h003);
        if (busy_n !== 1'b0)
        begin
            failures++;
            end_of_test();
        end
        cnt = 0;
        while (busy_n === 1'b0 && cnt < 200)
        begin
            @(negedge clk_sys);
            cnt++;
            if (cnt == 10)
            begin
                read_chk(2'h1, exp_reg[1]);
                cnt += 2;
            end
        end
        chk(12'(cnt), 12'(n) * 12'(sas_pkg::CONV_CYCLES));
        if (cnt >= 200 || busy_n !== 1'b1)
        begin
            failures++;
            end_of_test();
        end
        exp_reg = nxt;
        for (int a = 0; a < 4; a++)
            read_chk(a[1:0], exp_reg[a]);
    endtask : scn_sequence

    task automatic scn_no_select;
        logic [11:0] d;
        logic oe;
        host.read_reg(2'h3, 1'b0, d, oe);
        chk({11'h000, oe}, 12'h001);
        chk(d, 12'h000);
        read_chk(2'h3, exp_reg[3]);
    endtask : scn_no_select

    initial
    begin
        scn_reset();
        for (int i = 0; i < 8; i++)
            scn_sequence(i);
        scn_no_select();
        end_of_test();
    end
endmodule : tb_simultaneous_adc_sequencer
`default_nettype wire
